// ==== hw/fsps_sequencer.sv ====
// Flash self-program sequencer: control register, command windows, page operations.
//
// The plain strobed port and the address map were left to the implementer.
`default_nettype none
module fsps_sequencer #(
  parameter int PAGE_WORD_BITS = 5,
  parameter int PAGE_BITS      = 6,
  parameter int PROG_CYCLES    = fsps_pkg::PROG_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire fsps_pkg::fsps_bus_type   bus_i,
  output logic      [7:0]            rdata_o,
  input  wire fsps_pkg::fsps_instr_type instr_i,
  output logic      [7:0]            load_data_o,
  output logic                       cpu_halt_o,
  input  wire logic                  eeprom_write_busy_i,
  input  wire logic [7:0]            fuse_low_byte_i,
  input  wire logic [7:0]            fuse_high_byte_i,
  input  wire logic [7:0]            lock_bits_i
);
  localparam int AW = PAGE_WORD_BITS + PAGE_BITS;

  // Elaboration checks; a page operation must sweep every word of the page.
  if (AW > 15)
  begin : g_aw_check
    $error("fsps_sequencer: flash word address must fit the pointer");
  end
  if (PROG_CYCLES < (1 << PAGE_WORD_BITS) + 1)
  begin : g_prog_check
    $error("fsps_sequencer: PROG_CYCLES must cover a whole page sweep");
  end

  fsps_pkg::fsps_state_type state_reg, state_next;
  logic [4:0]  ctrl_reg, ctrl_next;
  logic [2:0]  win_reg, win_next;
  logic [31:0] prog_cnt_reg, prog_cnt_next;
  logic [PAGE_WORD_BITS-1:0] sweep_reg, sweep_next;
  logic [PAGE_BITS-1:0]      page_reg, page_next;
  logic        loading_reg, loading_next;
  logic        byte_sel_reg;
  logic        fuse_sel_reg;
  logic [7:0]  fuse_data_reg;
  logic [15:0] buf_rdata;
  logic [15:0] flash_rdata;

  // ==========================================================================
  // Register bus decode.
  wire       cs_hit     = bus_i.addr == fsps_pkg::SPM_CS_OFFSET;
  wire       cs_wr      = bus_i.wr && cs_hit;
  wire       cs_rd      = bus_i.rd && cs_hit;
  wire [4:0] wr_code    = bus_i.wdata[4:0];
  wire       code_ok    = wr_code == fsps_pkg::CMD_CLEAR_BUF
                       || wr_code == fsps_pkg::CMD_READ_FUSE
                       || wr_code == fsps_pkg::CMD_PAGE_WRITE
                       || wr_code == fsps_pkg::CMD_PAGE_ERASE
                       || wr_code == fsps_pkg::CMD_LOAD_WORD;
  wire       idle       = state_reg == fsps_pkg::FSPS_IDLE;
  wire       accept_wr  = cs_wr && code_ok && idle && !eeprom_write_busy_i;
  wire       armed      = idle && ctrl_reg[fsps_pkg::STORE_EN_POS];
  wire       store_go   = armed && instr_i.store && win_reg != 3'h0;
  wire       fuse_armed = armed && ctrl_reg[fsps_pkg::READ_FUSE_POS];
  wire       load_ok    = fuse_armed && win_reg > 3'(fsps_pkg::STORE_WINDOW_CYC
                                                   - fsps_pkg::LOAD_WINDOW_CYC);
  wire       fuse_read  = load_ok && instr_i.load;
  wire [PAGE_WORD_BITS-1:0] ptr_word = instr_i.ptr[PAGE_WORD_BITS:1];
  wire [PAGE_BITS-1:0]      ptr_page = instr_i.ptr[AW:PAGE_WORD_BITS+1];
  wire       is_load    = ctrl_reg == fsps_pkg::CMD_LOAD_WORD;
  wire       is_clear   = ctrl_reg == fsps_pkg::CMD_CLEAR_BUF;
  wire       load_we    = store_go && is_load;
  wire       write_done = state_reg == fsps_pkg::FSPS_WRITE && prog_cnt_reg == 32'h1;
  wire       buf_clear  = write_done || (store_go && is_clear)
                       || (loading_reg && eeprom_write_busy_i);
  wire       busy       = !idle;

  // ==========================================================================
  // Command sequencing.
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    win_next      = win_reg;
    state_next    = state_reg;
    prog_cnt_next = prog_cnt_reg;
    sweep_next    = sweep_reg;
    page_next     = page_reg;
    loading_next  = loading_reg;
    if (accept_wr)
    begin
      ctrl_next = wr_code;
      win_next  = 3'(fsps_pkg::STORE_WINDOW_CYC);
    end
    else if (idle)
    begin
      if (win_reg != 3'h0)
        win_next = win_reg - 3'h1;
      if (win_reg == 3'h1 || fuse_read || (store_go && !ctrl_reg[fsps_pkg::PAGE_ERASE_POS]
                                           && !ctrl_reg[fsps_pkg::PAGE_WRITE_POS]))
      begin
        ctrl_next = 5'h00;
        win_next  = 3'h0;
      end
      if (store_go && ctrl_reg == fsps_pkg::CMD_PAGE_ERASE)
      begin
        state_next    = fsps_pkg::FSPS_ERASE;
        page_next     = ptr_page;
        prog_cnt_next = 32'(PROG_CYCLES);
        win_next      = 3'h0;
      end
      else if (store_go && ctrl_reg == fsps_pkg::CMD_PAGE_WRITE)
      begin
        state_next    = fsps_pkg::FSPS_WRITE;
        page_next     = ptr_page;
        prog_cnt_next = 32'(PROG_CYCLES);
        win_next      = 3'h0;
      end
    end
    else
    begin
      sweep_next    = sweep_reg + PAGE_WORD_BITS'(1);
      prog_cnt_next = prog_cnt_reg - 32'h1;
      if (prog_cnt_reg == 32'h1)
      begin
        state_next = fsps_pkg::FSPS_IDLE;
        ctrl_next  = 5'h00;
        sweep_next = '0;
      end
    end
    if (load_we)
      loading_next = 1'b1;
    if (buf_clear)
      loading_next = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg    <= fsps_pkg::FSPS_IDLE;
      ctrl_reg     <= fsps_pkg::SPM_CS_RESET[4:0];
      win_reg      <= 3'h0;
      prog_cnt_reg <= 32'h0;
      sweep_reg    <= '0;
      page_reg     <= '0;
      loading_reg  <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      ctrl_reg     <= ctrl_next;
      win_reg      <= win_next;
      prog_cnt_reg <= prog_cnt_next;
      sweep_reg    <= sweep_next;
      page_reg     <= page_next;
      loading_reg  <= loading_next;
    end
  end

  // ==========================================================================
  // Read paths.
  // fuse inputs carry programmed-as-zero
  wire [7:0] fuse_val = (instr_i.ptr == fsps_pkg::PTR_FUSE_LOW)  ? fuse_low_byte_i  :
                        (instr_i.ptr == fsps_pkg::PTR_LOCK)      ? lock_bits_i      :
                        (instr_i.ptr == fsps_pkg::PTR_FUSE_HIGH) ? fuse_high_byte_i :
                                                                   8'hFF;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o       <= 8'h00;
      byte_sel_reg  <= 1'b0;
      fuse_sel_reg  <= 1'b0;
      fuse_data_reg <= 8'h00;
    end
    else
    begin
      rdata_o       <= cs_rd ? {3'b000, ctrl_reg} : 8'h00;
      byte_sel_reg  <= instr_i.ptr[0];
      fuse_sel_reg  <= fuse_read;
      fuse_data_reg <= fuse_val;
    end
  end

  assign load_data_o = fuse_sel_reg ? fuse_data_reg
                     : (byte_sel_reg ? flash_rdata[15:8] : flash_rdata[7:0]);
  assign cpu_halt_o  = busy;

  // ==========================================================================
  // Storage.
  // random order loads
  fsps_page_buffer #(
    .WORDS (1 << PAGE_WORD_BITS),
    .AW    (PAGE_WORD_BITS)
  ) u_buf (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .clear_i  (buf_clear),
    .we_i     (load_we),
    .waddr_i  (ptr_word),
    .wdata_i  (instr_i.data),
    .raddr_i  (sweep_reg),
    .rdata_o  (buf_rdata)
  );

  // Read data lags the sweep by one word, so the write address is the previous word.
  fsps_flash_array #(
    .PAGES (1 << PAGE_BITS),
    .PW    (PAGE_BITS),
    .WB    (PAGE_WORD_BITS)
  ) u_flash (
    .clk_i   (clk_i),
    .erase_i (state_reg == fsps_pkg::FSPS_ERASE),
    .write_i (state_reg == fsps_pkg::FSPS_WRITE && prog_cnt_reg != 32'(PROG_CYCLES)),
    .page_i  (page_reg),
    .word_i  (state_reg == fsps_pkg::FSPS_WRITE ? sweep_reg - PAGE_WORD_BITS'(1)
                                                 : sweep_reg),
    .wdata_i (buf_rdata),
    .raddr_i (instr_i.ptr[AW:1]),
    .rdata_o (flash_rdata)
  );
endmodule
`default_nettype wire

// ==== hw/fsps_pkg.sv ====
// Package with constants and carrier types of the flash self-program sequencer.
`default_nettype none
package fsps_pkg;
  // ==========================================================================
  // Control/status register layout
  localparam logic [7:0] SPM_CS_OFFSET     = 8'h37;
  localparam int         CLEAR_BUF_POS     = 4;
  localparam int         READ_FUSE_POS     = 3;
  localparam int         PAGE_WRITE_POS    = 2;
  localparam int         PAGE_ERASE_POS    = 1;
  localparam int         STORE_EN_POS      = 0;
  localparam logic [7:0] SPM_CS_RESET      = 8'h00;
  localparam logic [4:0] CMD_CLEAR_BUF     = 5'h11;
  localparam logic [4:0] CMD_READ_FUSE     = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE    = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE    = 5'h03;
  localparam logic [4:0] CMD_LOAD_WORD     = 5'h01;
  // ==========================================================================
  // Fuse and lock read pointers
  localparam logic [15:0] PTR_FUSE_LOW     = 16'h0000;
  localparam logic [15:0] PTR_LOCK         = 16'h0001;
  localparam logic [15:0] PTR_FUSE_HIGH    = 16'h0003;
  // ==========================================================================
  // Timing
  localparam int         STORE_WINDOW_CYC  = 4;
  localparam int         LOAD_WINDOW_CYC   = 3;
  localparam int         CLK_PERIOD_NS     = 10;
  localparam int         PROG_TIME_US      = 3700;
  localparam int         PROG_CYC          = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } fsps_bus_type;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] ptr;
    logic [15:0] data;
  } fsps_instr_type;

  typedef enum logic [1:0] {
    FSPS_IDLE  = 2'b00,
    FSPS_ERASE = 2'b01,
    FSPS_WRITE = 2'b10
  } fsps_state_type;
endpackage
`default_nettype wire

// ==== hw/fsps_page_buffer.sv ====
// Temporary page buffer with per-entry valid bits and registered read data.
`default_nettype none
module fsps_page_buffer #(
  parameter int WORDS = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  input  wire logic          clear_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [15:0]   rdata_o
);
  // Elaboration check on the parameters.
  if (WORDS != (1 << AW))
  begin : g_words_check
    $error("fsps_page_buffer: WORDS must equal 2**AW");
  end

  logic [15:0]      mem_reg [WORDS];
  logic [WORDS-1:0] valid_reg;

  // ==========================================================================
  // Storage; cleared entries read as erased flash.
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem_reg[waddr_i] <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      valid_reg <= '0;
    else if (clear_i)
      valid_reg <= '0;
    else if (we_i)
      valid_reg[waddr_i] <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 16'hFFFF;
    else
      rdata_o <= valid_reg[raddr_i] ? mem_reg[raddr_i] : 16'hFFFF;
  end
endmodule
`default_nettype wire

// ==== hw/fsps_flash_array.sv ====
// Program flash array model with page erase, page write and word read.
`default_nettype none
module fsps_flash_array #(
  parameter int PAGES = 64,
  parameter int PW    = 6,
  parameter int WB    = 5
) (
  input  wire logic               clk_i,
  input  wire logic               erase_i,
  input  wire logic               write_i,
  input  wire logic [PW-1:0]      page_i,
  input  wire logic [WB-1:0]      word_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic [PW+WB-1:0]   raddr_i,
  output logic      [15:0]        rdata_o
);
  // Elaboration check on the parameters.
  if (PAGES != (1 << PW))
  begin : g_pages_check
    $error("fsps_flash_array: PAGES must equal 2**PW");
  end

  logic [15:0] mem_reg [PAGES << WB];

  // ==========================================================================
  // One word per cycle is erased or written while a page operation runs.
  always_ff @(posedge clk_i)
  begin
    if (erase_i)
      mem_reg[{page_i, word_i}] <= 16'hFFFF;
    else if (write_i)
      mem_reg[{page_i, word_i}] <= mem_reg[{page_i, word_i}] & wdata_i;
    rdata_o <= mem_reg[raddr_i];
  end
endmodule
`default_nettype wire

// ==== sim/fsps_sequencer_props.sv ====
// Port-level assertion checker for the flash self-program sequencer.
`default_nettype none
module fsps_sequencer_props #(
  parameter int PROG_CYCLES = fsps_pkg::PROG_CYC
) (
  input wire logic                     clk_i,
  input wire logic                     resetn_i,
  input wire fsps_pkg::fsps_bus_type   bus_i,
  input wire logic [7:0]               rdata_o,
  input wire fsps_pkg::fsps_instr_type instr_i,
  input wire logic [7:0]               load_data_o,
  input wire logic                     cpu_halt_o,
  input wire logic                     eeprom_write_busy_i,
  input wire logic [7:0]               fuse_low_byte_i,
  input wire logic [7:0]               fuse_high_byte_i,
  input wire logic [7:0]               lock_bits_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ========================================
  // Halt length counter
  logic [31:0] halt_cnt_reg;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      halt_cnt_reg <= '0;
    else
      halt_cnt_reg <= cpu_halt_o ? halt_cnt_reg + 32'h1 : '0;
  // ========================================
  // Command arming sequences
  sequence arm_s(logic [4:0] code);
    bus_i.wr && bus_i.addr == 8'h37 && bus_i.wdata[4:0] == code &&
      !cpu_halt_o && !eeprom_write_busy_i;
  endsequence
  sequence late_store_s;
    arm_s(fsps_pkg::CMD_PAGE_ERASE) ##1 (!bus_i.wr && !instr_i.store)[*4] ##1 instr_i.store;
  endsequence
  // ========================================
  // Properties
  read_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  reserved_bits_a: assert property (bus_i.rd |=> rdata_o[7:5] == 3'b000)
    else $error("reserved control bits not zero");
  readback_a: assert property (arm_s(fsps_pkg::CMD_LOAD_WORD) ##1
    (!bus_i.wr && !instr_i.store) ##1
    (bus_i.rd && bus_i.addr == 8'h37) |=> rdata_o == 8'h01)
    else $error("control readback wrong");
  halt_cause_a: assert property ($rose(cpu_halt_o) |-> $past(instr_i.store))
    else $error("halt without a store");
  halt_length_a: assert property ($fell(cpu_halt_o) |-> halt_cnt_reg == PROG_CYCLES)
    else $error("halt length wrong");
  erase_start_a: assert property (arm_s(fsps_pkg::CMD_PAGE_ERASE) ##[1:4] instr_i.store
    |=> cpu_halt_o[*8])
    else $error("erase did not halt the core");
  write_start_a: assert property (arm_s(fsps_pkg::CMD_PAGE_WRITE) ##[1:4] instr_i.store
    |=> cpu_halt_o)
    else $error("page write did not halt the core");
  window_expiry_a: assert property (late_store_s |=> !cpu_halt_o)
    else $error("store after window took effect");
  eeprom_block_a: assert property (eeprom_write_busy_i[*6] |-> !$rose(cpu_halt_o))
    else $error("command ran during eeprom write");
  lock_read_a: assert property (arm_s(fsps_pkg::CMD_READ_FUSE) ##[1:3]
    (instr_i.load && instr_i.ptr == 16'h0001) |=> load_data_o == $past(lock_bits_i))
    else $error("lock read wrong");
endmodule

bind fsps_sequencer fsps_sequencer_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .instr_i(instr_i), .load_data_o(load_data_o), .cpu_halt_o(cpu_halt_o),
  .eeprom_write_busy_i(eeprom_write_busy_i), .fuse_low_byte_i(fuse_low_byte_i),
  .fuse_high_byte_i(fuse_high_byte_i), .lock_bits_i(lock_bits_i));
`default_nettype wire

// ==== sim/fsps_cpu_model.sv ====
// Behavioural core issuing store and load program instructions.
`default_nettype none
module fsps_cpu_model (
  input  wire logic                     clk_i,
  input  wire logic [7:0]               load_data_i,
  output var  fsps_pkg::fsps_instr_type instr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial instr_o = '0;
  // ========================================
  // Store cycle, operands scrambled once released
  task automatic store(input logic [15:0] ptr, input logic [15:0] data);
    @(posedge clk_i);
    instr_o <= {1'b1, 1'b0, ptr, data};
    @(posedge clk_i);
    instr_o <= {1'b0, 1'b0, ~ptr, ~data};
  endtask
  // Load cycle, result taken in the following cycle
  task automatic load(input logic [15:0] ptr, output logic [7:0] q);
    @(posedge clk_i);
    instr_o <= {1'b0, 1'b1, ptr, 16'h0000};
    @(posedge clk_i);
    instr_o <= {1'b0, 1'b0, ~ptr, 16'hFFFF};
    @(negedge clk_i);
    q = load_data_i;
  endtask
endmodule
`default_nettype wire

// ==== sim/fsps_sequencer_tb_top.sv ====
// Self-checking testbench for the flash self-program sequencer.
`default_nettype none
module fsps_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PROG    = 40;
  localparam logic [7:0] FUSE_LO = 8'h62;
  localparam logic [7:0] FUSE_HI = 8'hDF;
  localparam logic [7:0] LOCKB   = 8'hFC;
  logic                     clk_i    = 1'b0;
  logic                     resetn_i = 1'b0;
  logic                     busy     = 1'b0;
  fsps_pkg::fsps_bus_type   bus      = '0;
  fsps_pkg::fsps_instr_type instr;
  logic [7:0]               rdata;
  logic [7:0]               load_data;
  logic [7:0]               q;
  logic [7:0]               n;
  logic                     halt;
  int                       n_mismatch   = 0;
  int                       total_checks = 0;
  logic [4:0]  codes [5] = '{5'h11, 5'h09, 5'h05, 5'h03, 5'h01};
  logic [15:0] fptr [3]  = '{16'h0000, 16'h0001, 16'h0003};
  logic [7:0]  fexp [3]  = '{FUSE_LO, LOCKB, FUSE_HI};
  always #5 clk_i = ~clk_i;
  fsps_sequencer #(.PROG_CYCLES(PROG)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
    .instr_i(instr), .load_data_o(load_data), .cpu_halt_o(halt),
    .eeprom_write_busy_i(busy), .fuse_low_byte_i(FUSE_LO),
    .fuse_high_byte_i(FUSE_HI), .lock_bits_i(LOCKB));
  fsps_cpu_model cpu (.clk_i(clk_i), .load_data_i(load_data), .instr_o(instr));
  // ========================================
  // Access and compare tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clk_i);
    bus <= '0;
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    bus <= '0;
    @(negedge clk_i);
    chk(name, exp, rdata);
  endtask
  task automatic run_op(input logic [4:0] c, input logic [15:0] p, input logic [15:0] d);
    wr(8'h37, {3'b000, c});
    cpu.store(p, d);
    n = 8'h00;
    @(negedge clk_i);
    while (halt && n < 8'd200)
    begin
      n++;
      @(negedge clk_i);
    end
  endtask
  function automatic logic [15:0] za(input int pg, input int wd, input int b);
    return 16'(pg * 64 + wd * 2 + b);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ========================================
  // Watchdog
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  // ========================================
  // Test sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdchk("ctrl reset", 8'h37, 8'h00);
    rdchk("unmapped", 8'h10, 8'h00);
    foreach (codes[i])
    begin
      wr(8'h37, {3'b111, codes[i]});
      rdchk("ctrl code", 8'h37, {3'b000, codes[i]});
    end
    repeat (6) @(posedge clk_i);
    rdchk("ctrl expired", 8'h37, 8'h00);
    wr(8'h37, 8'h02);
    rdchk("ctrl illegal", 8'h37, 8'h00);
    foreach (fptr[i])
    begin
      wr(8'h37, 8'h09);
      cpu.load(fptr[i], q);
      chk("fuse read", fexp[i], q);
    end
    wr(8'h37, 8'h03);
    repeat (3) @(posedge clk_i);
    cpu.store(za(1, 0, 0), 16'h0000);
    @(negedge clk_i);
    chk("late store", 8'h00, {7'h00, halt});
    run_op(fsps_pkg::CMD_CLEAR_BUF, 16'h0000, 16'h0000);
    run_op(fsps_pkg::CMD_LOAD_WORD, za(2, 3, 0), 16'h1234);
    run_op(fsps_pkg::CMD_LOAD_WORD, za(2, 0, 0), 16'hABCD);
    run_op(fsps_pkg::CMD_PAGE_ERASE, 16'hF000 | za(2, 7, 1), 16'h5555);
    chk("erase halt", 8'(PROG), n);
    run_op(fsps_pkg::CMD_PAGE_WRITE, za(2, 0, 0), 16'h5555);
    chk("write halt", 8'(PROG), n);
    cpu.load(za(2, 3, 0), q);
    chk("low byte", 8'h34, q);
    cpu.load(za(2, 3, 1), q);
    chk("high byte", 8'h12, q);
    cpu.load(za(2, 0, 1), q);
    chk("word zero", 8'hAB, q);
    cpu.load(za(2, 1, 0), q);
    chk("unloaded word", 8'hFF, q);
    run_op(fsps_pkg::CMD_PAGE_ERASE, za(3, 0, 0), 16'h0000);
    run_op(fsps_pkg::CMD_PAGE_WRITE, za(3, 0, 0), 16'h0000);
    cpu.load(za(3, 3, 0), q);
    chk("buffer cleared", 8'hFF, q);
    run_op(fsps_pkg::CMD_LOAD_WORD, za(4, 5, 0), 16'h0000);
    @(posedge clk_i);
    busy <= 1'b1;
    repeat (2) @(posedge clk_i);
    busy <= 1'b0;
    run_op(fsps_pkg::CMD_LOAD_WORD, za(4, 6, 0), 16'h0000);
    run_op(fsps_pkg::CMD_PAGE_ERASE, za(4, 0, 0), 16'h0000);
    run_op(fsps_pkg::CMD_PAGE_WRITE, za(4, 0, 0), 16'h0000);
    cpu.load(za(4, 5, 0), q);
    chk("load discarded", 8'hFF, q);
    cpu.load(za(4, 6, 0), q);
    chk("load kept", 8'h00, q);
    run_op(fsps_pkg::CMD_LOAD_WORD, za(6, 2, 0), 16'h0000);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdchk("ctrl after reset", 8'h37, 8'h00);
    run_op(fsps_pkg::CMD_PAGE_ERASE, za(6, 0, 0), 16'h0000);
    run_op(fsps_pkg::CMD_PAGE_WRITE, za(6, 0, 0), 16'h0000);
    cpu.load(za(6, 2, 0), q);
    chk("reset clears buffer", 8'hFF, q);
    @(posedge clk_i);
    busy <= 1'b1;
    repeat (2) @(posedge clk_i);
    run_op(fsps_pkg::CMD_PAGE_ERASE, za(5, 0, 0), 16'h0000);
    chk("blocked erase", 8'h00, n);
    rdchk("ctrl blocked", 8'h37, 8'h00);
    busy <= 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
